// ### hdl/uft_pkg.sv
// Shared constants, types and decoding functions of the serial frame transmitter.
package uft_pkg;

	// Register offsets on the plain register port.
	localparam logic [2:0] ADDR_DATA    = 3'h0;
	localparam logic [2:0] ADDR_STATUS  = 3'h1;
	localparam logic [2:0] ADDR_CTRL    = 3'h2;
	localparam logic [2:0] ADDR_FORMAT  = 3'h3;
	localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
	localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

	// Status bit positions.
	localparam int ST_BUF_EMPTY = 0;
	localparam int ST_TX_DONE   = 1;
	localparam int ST_FRAME_ERR = 2;

	// Control bit positions.
	localparam int CT_TX_EN     = 0;
	localparam int CT_RX_EN     = 1;
	localparam int CT_NINTH     = 2;
	localparam int CT_DOUBLE    = 3;
	localparam int CT_SYNC      = 4;
	localparam int CT_XCK_MSTR  = 5;

	// Format field positions.
	localparam int FM_SIZE_LSB  = 0;
	localparam int FM_PAR_ODD   = 3;
	localparam int FM_PAR_EN    = 4;
	localparam int FM_STOP2     = 5;

	// Reset values.
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  FORMAT_RST = 8'h03;
	localparam logic [11:0] BAUD_RST   = 12'h000;

	// Character size code for nine data bits.
	localparam logic [2:0]  SIZE_NINE  = 3'h7;

	// Last prescaler step per bit in normal and double speed.
	localparam logic [3:0]  PRE_NORMAL_LAST = 4'hf;
	localparam logic [3:0]  PRE_DOUBLE_LAST = 4'h7;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_PARITY,
		TX_STOP1,
		TX_STOP2
	} uft_tx_state_t;

	// Number of data bits for a size code; reserved codes act as eight.
	function automatic logic [3:0] data_bits(input logic [2:0] size);
		logic [3:0] n;
		n = 4'h8;
		if (size == SIZE_NINE)
			n = 4'h9;
		else if (size < 3'h4)
			n = 4'h5 + {2'h0, size[1:0]};
		return n;
	endfunction

	// Mask that keeps only the data bits of a character.
	function automatic logic [8:0] data_mask(input logic [2:0] size);
		logic [8:0] m;
		m = 9'h000;
		for (int i = 0; i < 9; i++)
			m[i] = (i < int'(data_bits(size)));
		return m;
	endfunction

endpackage

// ### hdl/uft_baud.sv
// Bit rate generator with transfer clock master output and slave edge detection.
module uft_baud (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Configuration.
	input  wire logic [11:0] baud_divisor,
	input  wire logic        divisor_reload,
	input  wire logic        double_speed_select,
	input  wire logic        sync_mode,
	input  wire logic        xck_master,
	// Transfer clock pin.
	input  wire logic        transfer_clock_pin_in,
	output logic             transfer_clock_pin_out,
	output logic             transfer_clock_pin_oe,
	// Bit timing.
	output logic             bit_tick
);

	typedef struct packed {
		logic [11:0] cnt;
		logic [3:0]  pre;
		logic        xck;
		logic        s1;
		logic        s2;
		logic        s3;
	} uft_baud_state_t;

	uft_baud_state_t s_q;
	uft_baud_state_t s_d;
	logic            base_tick;
	logic [3:0]      pre_last;

	always_comb
	begin
		s_d       = s_q;
		base_tick = (s_q.cnt == 12'h000);
		pre_last  = double_speed_select ? uft_pkg::PRE_DOUBLE_LAST : uft_pkg::PRE_NORMAL_LAST;
		if (base_tick || divisor_reload)
			s_d.cnt = baud_divisor;
		else
			s_d.cnt = s_q.cnt - 12'h001;
		if (base_tick)
			s_d.pre = (s_q.pre >= pre_last) ? 4'h0 : s_q.pre + 4'h1;
		if (base_tick && sync_mode && xck_master)
			s_d.xck = ~s_q.xck;
		else if (!(sync_mode && xck_master))
			s_d.xck = 1'b0;
		s_d.s1 = transfer_clock_pin_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		// Bits change on the rising transfer clock edge in both synchronous roles.
		if (!sync_mode)
			bit_tick = base_tick && (s_q.pre >= pre_last);
		else if (xck_master)
			bit_tick = base_tick && !s_q.xck;
		else
			bit_tick = s_q.s2 && !s_q.s3;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign transfer_clock_pin_out = s_q.xck;
	assign transfer_clock_pin_oe  = sync_mode && xck_master;

endmodule

// ### hdl/uft_rxstop.sv
// Receive side frame walker that checks only the first stop bit.
module uft_rxstop (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Shared frame format.
	input  wire logic       rx_enable,
	input  wire logic [2:0] char_size_field,
	input  wire logic       parity_enable,
	input  wire logic       bit_tick,
	// Serial input pin.
	input  wire logic       serial_in_pin,
	// Result.
	output logic            frame_error_pulse
);

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       busy;
		logic [3:0] cnt;
		logic       fe;
	} uft_rxstop_state_t;

	uft_rxstop_state_t s_q;
	uft_rxstop_state_t s_d;
	logic [3:0]        last;

	always_comb
	begin
		s_d    = s_q;
		s_d.s1 = serial_in_pin;
		s_d.s2 = s_q.s1;
		s_d.fe = 1'b0;
		last   = uft_pkg::data_bits(char_size_field) + {3'h0, parity_enable};
		if (!rx_enable)
			s_d.busy = 1'b0;
		else if (bit_tick && !s_q.busy && !s_q.s2)
		begin
			s_d.busy = 1'b1;
			s_d.cnt  = 4'h0;
		end
		else if (bit_tick && s_q.busy)
		begin
			if (s_q.cnt == last)
			begin
				// A second stop bit is never looked at.
				s_d.fe   = !s_q.s2;
				s_d.busy = 1'b0;
			end
			else
				s_d.cnt = s_q.cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_q <= '{s1: 1'b1, s2: 1'b1, default: '0};
		else
			s_q <= s_d;
	end

	assign frame_error_pulse = s_q.fe;

endmodule

// ### hdl/uft_top.sv
// Register file, transmit buffer and frame shifter of the serial transmitter.
//
// What this block does
// - Support all thirty frame formats.
// - Send data least significant bit first.
// - Parity bit follows last data bit.
// - Next frame may follow without gap.
// - Stop bits and idle line high.
// - One shared format for receive and transmit.
// - Frame error from first stop only.
// - Parity is XOR, inverted when odd.
// - Size seven sends ninth bit too.
// - Transmit enable takes the output pin.
// - Synchronous mode shifts on transfer clock.
// - Data write loads buffer, starts sending.
// - Buffer moves when shifter idle or done.
// - Whole frame at configured bit rate.
// - Unused upper data bits never sent.
// - Buffer empty flag tracks buffer content.
// - Complete flag set at end, write-one clears.
// - Disable waits until buffer, shifter empty.
module uft_top (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Register port.
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Serial pins.
	output logic            serial_out_pin,
	output logic            serial_out_pin_oe,
	input  wire logic       serial_in_pin,
	input  wire logic       transfer_clock_pin_in,
	output logic            transfer_clock_pin_out,
	output logic            transfer_clock_pin_oe
);

	typedef struct packed {
		logic [7:0]              ctrl;
		logic [7:0]              fmt;
		logic [11:0]             baud;
		logic [8:0]              buf_data;
		logic                    buf_full;
		logic [8:0]              frame;
		logic [3:0]              bit_idx;
		uft_pkg::uft_tx_state_t  st;
		logic                    active;
		logic                    tx_done;
		logic                    frame_err;
		logic                    out;
		logic [7:0]              rdata;
	} uft_top_state_t;

	uft_top_state_t s_q;
	uft_top_state_t s_d;
	logic           bit_tick;
	logic           fe_pulse;
	logic           wr_data;
	logic           wr_baud_lo;
	logic           done_set;
	logic           finish;
	logic [3:0]     nbits;
	logic           par_en;
	logic           busy;

	uft_baud u_baud (
		.ref_clk                (ref_clk),
		.rst                    (rst),
		.baud_divisor           (s_q.baud),
		.divisor_reload         (wr_baud_lo),
		.double_speed_select    (s_q.ctrl[uft_pkg::CT_DOUBLE]),
		.sync_mode              (s_q.ctrl[uft_pkg::CT_SYNC]),
		.xck_master             (s_q.ctrl[uft_pkg::CT_XCK_MSTR]),
		.transfer_clock_pin_in  (transfer_clock_pin_in),
		.transfer_clock_pin_out (transfer_clock_pin_out),
		.transfer_clock_pin_oe  (transfer_clock_pin_oe),
		.bit_tick               (bit_tick)
	);

	uft_rxstop u_rxstop (
		.ref_clk           (ref_clk),
		.rst               (rst),
		.rx_enable         (s_q.ctrl[uft_pkg::CT_RX_EN]),
		.char_size_field   (s_q.fmt[2:0]),
		.parity_enable     (s_q.fmt[uft_pkg::FM_PAR_EN]),
		.bit_tick          (bit_tick),
		.serial_in_pin     (serial_in_pin),
		.frame_error_pulse (fe_pulse)
	);

	always_comb
	begin
		s_d        = s_q;
		wr_data    = reg_wr && (reg_addr == uft_pkg::ADDR_DATA);
		wr_baud_lo = reg_wr && (reg_addr == uft_pkg::ADDR_BAUD_LO);
		done_set   = 1'b0;
		finish     = 1'b0;
		// The live format feeds both directions, so changing it mid-frame corrupts both.
		nbits      = uft_pkg::data_bits(s_q.fmt[2:0]);
		par_en     = s_q.fmt[uft_pkg::FM_PAR_EN];

		if (bit_tick)
		begin
			case (s_q.st)
				uft_pkg::TX_IDLE:
				begin
					finish = 1'b1;
				end
				uft_pkg::TX_START:
				begin
					s_d.st      = uft_pkg::TX_DATA;
					s_d.bit_idx = 4'h0;
					s_d.out     = s_q.frame[0];
				end
				uft_pkg::TX_DATA:
				begin
					if (s_q.bit_idx == nbits - 4'h1)
					begin
						if (par_en)
						begin
							s_d.st  = uft_pkg::TX_PARITY;
							s_d.out = (^s_q.frame) ^ s_q.fmt[uft_pkg::FM_PAR_ODD];
						end
						else
						begin
							s_d.st  = uft_pkg::TX_STOP1;
							s_d.out = 1'b1;
						end
					end
					else
					begin
						s_d.bit_idx = s_q.bit_idx + 4'h1;
						s_d.out     = s_q.frame[s_q.bit_idx + 4'h1];
					end
				end
				uft_pkg::TX_PARITY:
				begin
					s_d.st  = uft_pkg::TX_STOP1;
					s_d.out = 1'b1;
				end
				uft_pkg::TX_STOP1:
				begin
					if (s_q.fmt[uft_pkg::FM_STOP2])
					begin
						s_d.st  = uft_pkg::TX_STOP2;
						s_d.out = 1'b1;
					end
					else
					begin
						finish   = 1'b1;
						done_set = !s_q.buf_full;
					end
				end
				default:
				begin
					finish   = 1'b1;
					done_set = !s_q.buf_full;
				end
			endcase
			// Reload straight after the last stop bit, or start from idle.
			if (finish && s_q.active && s_q.buf_full)
			begin
				s_d.st       = uft_pkg::TX_START;
				s_d.frame    = s_q.buf_data & uft_pkg::data_mask(s_q.fmt[2:0]);
				s_d.buf_full = 1'b0;
				s_d.out      = 1'b0;
			end
			else if (finish)
			begin
				s_d.st  = uft_pkg::TX_IDLE;
				s_d.out = 1'b1;
			end
		end

		// Register writes come after the shifter so a fresh load is never lost.
		if (wr_data)
		begin
			s_d.buf_data = {s_q.ctrl[uft_pkg::CT_NINTH], reg_wdata};
			s_d.buf_full = 1'b1;
		end
		else if (reg_wr && reg_addr == uft_pkg::ADDR_STATUS)
		begin
			if (reg_wdata[uft_pkg::ST_TX_DONE])
				s_d.tx_done = 1'b0;
			if (reg_wdata[uft_pkg::ST_FRAME_ERR])
				s_d.frame_err = 1'b0;
		end
		else if (reg_wr && reg_addr == uft_pkg::ADDR_CTRL)
			s_d.ctrl = reg_wdata;
		else if (reg_wr && reg_addr == uft_pkg::ADDR_FORMAT)
			s_d.fmt = reg_wdata;
		else if (wr_baud_lo)
			s_d.baud[7:0] = reg_wdata;
		else if (reg_wr && reg_addr == uft_pkg::ADDR_BAUD_HI)
			s_d.baud[11:8] = reg_wdata[3:0];

		// Set wins over a clear in the same cycle.
		if (done_set)
			s_d.tx_done = 1'b1;
		if (fe_pulse)
			s_d.frame_err = 1'b1;

		// Enable drops only once buffer and shifter are both empty.
		busy       = (s_q.st != uft_pkg::TX_IDLE) || s_q.buf_full;
		s_d.active = s_d.ctrl[uft_pkg::CT_TX_EN] || (s_q.active && busy);

		s_d.rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == uft_pkg::ADDR_STATUS)
				s_d.rdata = {5'h00, s_q.frame_err, s_q.tx_done, !s_q.buf_full};
			else if (reg_addr == uft_pkg::ADDR_CTRL)
				s_d.rdata = s_q.ctrl;
			else if (reg_addr == uft_pkg::ADDR_FORMAT)
				s_d.rdata = s_q.fmt;
			else if (reg_addr == uft_pkg::ADDR_BAUD_LO)
				s_d.rdata = s_q.baud[7:0];
			else if (reg_addr == uft_pkg::ADDR_BAUD_HI)
				s_d.rdata = {4'h0, s_q.baud[11:8]};
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_q <= '{ctrl: uft_pkg::CTRL_RST, fmt: uft_pkg::FORMAT_RST,
				baud: uft_pkg::BAUD_RST, st: uft_pkg::TX_IDLE, out: 1'b1, default: '0};
		else
			s_q <= s_d;
	end

	assign reg_rdata         = s_q.rdata;
	assign serial_out_pin    = s_q.out;
	assign serial_out_pin_oe = s_q.active;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_IDLE_HIGH: assert property (s_q.st == uft_pkg::TX_IDLE |-> serial_out_pin)
		else $error("idle line not high");

	AST_STOP_HIGH: assert property ((s_q.st == uft_pkg::TX_STOP1 ||
		s_q.st == uft_pkg::TX_STOP2) |-> serial_out_pin)
		else $error("stop bit not high");

	AST_START_LOW: assert property (s_q.st == uft_pkg::TX_START |->
		!serial_out_pin && $past(serial_out_pin || s_q.st == uft_pkg::TX_START))
		else $error("start bit not low");

	AST_DATA_ORDER: assert property (s_q.st == uft_pkg::TX_DATA |->
		serial_out_pin == s_q.frame[s_q.bit_idx])
		else $error("data bit out of order");

	AST_PARITY: assert property (s_q.st == uft_pkg::TX_PARITY |->
		serial_out_pin == ((^s_q.frame) ^ s_q.fmt[uft_pkg::FM_PAR_ODD]))
		else $error("parity bit wrong");

	AST_PARITY_PLACE: assert property ($rose(s_q.st == uft_pkg::TX_PARITY) |->
		$past(s_q.st) == uft_pkg::TX_DATA && par_en)
		else $error("parity bit misplaced");

	AST_LOAD: assert property (wr_data |=> s_q.buf_full &&
		s_q.buf_data == {$past(s_q.ctrl[uft_pkg::CT_NINTH]), $past(reg_wdata)})
		else $error("data write did not fill buffer");

	AST_MOVE: assert property (bit_tick && s_q.st == uft_pkg::TX_IDLE && s_q.buf_full &&
		s_q.active && !wr_data |=> s_q.st == uft_pkg::TX_START && !s_q.buf_full)
		else $error("buffer not moved to shifter");

	AST_DONE: assert property (bit_tick && s_q.st == uft_pkg::TX_STOP1 &&
		!s_q.fmt[uft_pkg::FM_STOP2] && !s_q.buf_full |=> s_q.tx_done)
		else $error("complete flag not set");

	AST_HOLD_EN: assert property (s_q.active && !s_q.ctrl[uft_pkg::CT_TX_EN] &&
		s_q.buf_full |=> serial_out_pin_oe)
		else $error("pin released with data pending");

	AST_UPPER_MASK: assert property ($rose(s_q.st == uft_pkg::TX_START) |->
		(s_q.frame & ~uft_pkg::data_mask(s_q.fmt[2:0])) == 9'h000)
		else $error("unused data bits kept");

	AST_STOP2: assert property (bit_tick && s_q.st == uft_pkg::TX_STOP1 &&
		s_q.fmt[uft_pkg::FM_STOP2] |=> s_q.st == uft_pkg::TX_STOP2 && serial_out_pin)
		else $error("second stop bit missing");

	AST_PIN_FREE: assert property (s_q.active && !s_q.ctrl[uft_pkg::CT_TX_EN] && !reg_wr &&
		s_q.st == uft_pkg::TX_IDLE && !s_q.buf_full |=> !serial_out_pin_oe)
		else $error("pin kept after disable");

	AST_NINTH: assert property ($rose(s_q.st == uft_pkg::TX_START) &&
		s_q.fmt[2:0] == uft_pkg::SIZE_NINE |-> s_q.frame[8] == $past(s_q.buf_data[8]))
		else $error("ninth bit lost");

endmodule

// ### sim/uft_remote.sv
// Remote serial device: decodes frames on the transmit line and sends frames back.
module uft_remote (
	// Clock.
	input  wire logic       ref_clk,
	// Serial lines.
	input  wire logic       serial_out_pin,
	input  wire logic       serial_out_pin_oe,
	output logic            serial_in_pin,
	output logic            transfer_clock_pin_in,
	// Frame shape.
	input  wire logic [4:0] bit_clks,
	input  wire logic [3:0] frame_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        line;
	logic        line_prev;
	logic [12:0] frm_q[$];
	int          t_q[$];
	int          cyc;
	logic [12:0] vec;
	// A released transmit line floats to its pull-up level.
	assign line = serial_out_pin_oe ? serial_out_pin : 1'b1;
	initial
	begin
		serial_in_pin = 1'b1;
		transfer_clock_pin_in = 1'b0;
		cyc = 0;
		line_prev = 1'b1;
	end
	always @(posedge ref_clk)
		cyc <= cyc + 1;
	// Syncs on the falling start edge, then samples every bit in its middle.
	initial
	begin
		forever
		begin
			@(posedge ref_clk);
			if (line_prev === 1'b1 && line === 1'b0)
			begin
				t_q.push_back(cyc);
				vec = 13'h0000;
				repeat (bit_clks / 2) @(posedge ref_clk);
				for (int i = 0; i < frame_len; i++)
				begin
					vec[i] = line;
					if (i < frame_len - 1)
						repeat (bit_clks) @(posedge ref_clk);
				end
				frm_q.push_back(vec);
			end
			line_prev = line;
		end
	end
	task automatic send_rx(input logic [12:0] bits, input logic [3:0] n);
		for (int i = 0; i < n; i++)
		begin
			serial_in_pin <= bits[i];
			repeat (bit_clks) @(posedge ref_clk);
		end
		serial_in_pin <= 1'b1;
	endtask
	// Runs the transfer clock for a set number of periods, then leaves it low.
	task automatic run_xck(input int n);
		repeat (n)
		begin
			repeat (bit_clks / 2) @(posedge ref_clk);
			transfer_clock_pin_in <= 1'b1;
			repeat (bit_clks / 2) @(posedge ref_clk);
			transfer_clock_pin_in <= 1'b0;
		end
	endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench of the serial frame transmitter against the remote model.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk;
	logic        rst;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        serial_out_pin;
	logic        serial_out_pin_oe;
	logic        serial_in_pin;
	logic        transfer_clock_pin_in;
	logic        transfer_clock_pin_out;
	logic        transfer_clock_pin_oe;
	logic [4:0]  bit_clks;
	logic [3:0]  frame_len;
	int          miscompares;
	int          compares;
	int          seed;
	int          t1;
	int          t2;
	int          n;
	logic        xp;
	logic [7:0]  s;
	logic [7:0]  fm;
	logic [8:0]  d;
	logic [8:0]  d2;
	logic [2:0]  szs[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [1:0]  pars[3] = '{2'h0, 2'h2, 2'h3};
	logic [2:0]  ra[5] = '{3'h2, 3'h3, 3'h1, 3'h6, 3'h7};
	logic [7:0]  re[5] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h00};
	uft_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe),
		.serial_in_pin(serial_in_pin), .transfer_clock_pin_in(transfer_clock_pin_in),
		.transfer_clock_pin_out(transfer_clock_pin_out),
		.transfer_clock_pin_oe(transfer_clock_pin_oe));
	uft_remote remote (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin),
		.serial_out_pin_oe(serial_out_pin_oe), .serial_in_pin(serial_in_pin),
		.transfer_clock_pin_in(transfer_clock_pin_in), .bit_clks(bit_clks),
		.frame_len(frame_len));
	always #20 ref_clk = ~ref_clk;
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic wait_st(input int b, input logic v);
		int k;
		k = 0;
		do
		begin
			rd(uft_pkg::ADDR_STATUS, s);
			k++;
		end
		while (s[b] !== v && k < 500);
		chk("status wait", {15'h0, s[b]}, {15'h0, v});
	endtask
	function automatic logic [3:0] flen(input logic [7:0] f);
		logic [3:0] n;
		n = (f[2:0] == 3'h7) ? 4'h9 : 4'h5 + {2'h0, f[1:0]};
		return 4'h2 + n + {3'h0, f[4]} + {3'h0, f[5]};
	endfunction
	function automatic logic [12:0] exp_frame(input logic [8:0] v, input logic [7:0] f);
		logic [12:0] r;
		logic        p;
		int          n;
		n = (f[2:0] == 3'h7) ? 9 : 5 + int'(f[1:0]);
		r = 13'h1ffe;
		p = f[3];
		for (int i = 0; i < n; i++)
		begin
			r[1 + i] = v[i];
			p = p ^ v[i];
		end
		if (f[4])
			r[1 + n] = p;
		return r & ((13'h0001 << flen(f)) - 13'h0001);
	endfunction
	task automatic send(input logic [8:0] v, input logic [7:0] f, input logic [7:0] ctl);
		frame_len <= flen(f);
		wr(uft_pkg::ADDR_FORMAT, f);
		wr(uft_pkg::ADDR_CTRL, ctl | {5'h0, v[8], 2'h0});
		wr(uft_pkg::ADDR_STATUS, 8'h02);
		wr(uft_pkg::ADDR_DATA, v[7:0]);
	endtask
	task automatic take(input logic [12:0] e, output int t);
		int k;
		k = 0;
		while (remote.frm_q.size() == 0 && k < 400)
		begin
			@(posedge ref_clk);
			k++;
		end
		t = (k < 400) ? remote.t_q.pop_front() : 0;
		chk("frame", {3'h0, (k < 400) ? remote.frm_q.pop_front() : 13'h0}, {3'h0, e});
	endtask
	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#(40 * 40000);
		miscompares++;
		wrap_up();
	end
	initial
	begin
		ref_clk = 1'b0;
		rst = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bit_clks = 5'h08;
		frame_len = 4'ha;
		seed = 6;
		miscompares = 0;
		compares = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		wr(3'h7, 8'hff);
		for (int i = 0; i < 5; i++)
		begin
			rd(ra[i], s);
			chk("reset value", {8'h0, s}, {8'h0, re[i]});
		end
		$display("test reset values done");
		wr(uft_pkg::ADDR_BAUD_HI, 8'h00);
		wr(uft_pkg::ADDR_BAUD_LO, 8'h00);
		for (int a = 0; a < 5; a++)
			for (int b = 0; b < 3; b++)
				for (int c = 0; c < 2; c++)
				begin
					fm = {2'h0, c[0], pars[b], szs[a]};
					d = 9'($random(seed));
					send(d, fm, 8'h0b);
					take(exp_frame(d, fm), t1);
					wait_st(uft_pkg::ST_TX_DONE, 1'b1);
				end
		$display("test frame formats done");
		d = 9'($random(seed));
		d2 = 9'($random(seed));
		send(d, 8'h03, 8'h0b);
		wait_st(uft_pkg::ST_BUF_EMPTY, 1'b1);
		wr(uft_pkg::ADDR_DATA, d2[7:0]);
		rd(uft_pkg::ADDR_STATUS, s);
		chk("buffer empty", {15'h0, s[0]}, 16'h0000);
		chk("tx complete", {15'h0, s[1]}, 16'h0000);
		chk("pin owned", {15'h0, serial_out_pin_oe}, 16'h0001);
		take(exp_frame(d, 8'h03), t1);
		take(exp_frame({1'b0, d2[7:0]}, 8'h03), t2);
		chk("frame spacing", 16'(t2 - t1), 16'h0050);
		wait_st(uft_pkg::ST_TX_DONE, 1'b1);
		wr(uft_pkg::ADDR_STATUS, 8'h02);
		rd(uft_pkg::ADDR_STATUS, s);
		chk("tx complete cleared", {8'h0, s}, 16'h0001);
		$display("test back to back done");
		wr(uft_pkg::ADDR_FORMAT, 8'h23);
		wr(uft_pkg::ADDR_STATUS, 8'h04);
		@(posedge ref_clk);
		remote.send_rx({2'b10, 8'h5a, 1'b0}, 4'hb);
		repeat (16) @(posedge ref_clk);
		rd(uft_pkg::ADDR_STATUS, s);
		chk("frame error", {15'h0, s[2]}, 16'h0001);
		wr(uft_pkg::ADDR_STATUS, 8'h04);
		rd(uft_pkg::ADDR_STATUS, s);
		chk("frame error cleared", {15'h0, s[2]}, 16'h0000);
		remote.send_rx({2'b01, 8'ha5, 1'b0}, 4'hb);
		repeat (110) @(posedge ref_clk);
		rd(uft_pkg::ADDR_STATUS, s);
		chk("second stop ignored", {15'h0, s[2]}, 16'h0000);
		$display("test frame error done");
		bit_clks <= 5'h10;
		d = 9'($random(seed));
		send(d, 8'h03, 8'h03);
		wr(uft_pkg::ADDR_CTRL, 8'h00);
		@(posedge ref_clk);
		chk("pin held", {15'h0, serial_out_pin_oe}, 16'h0001);
		take(exp_frame({1'b0, d[7:0]}, 8'h03), t1);
		repeat (40) @(posedge ref_clk);
		chk("pin released", {15'h0, serial_out_pin_oe}, 16'h0000);
		$display("test disable done");
		bit_clks <= 5'h04;
		wr(uft_pkg::ADDR_BAUD_LO, 8'h01);
		d = 9'($random(seed));
		send(d, 8'h03, 8'h31);
		@(posedge ref_clk);
		chk("clock pin owned", {15'h0, transfer_clock_pin_oe}, 16'h0001);
		take(exp_frame({1'b0, d[7:0]}, 8'h03), t1);
		xp = transfer_clock_pin_out;
		n = 0;
		repeat (40)
		begin
			@(posedge ref_clk);
			if (transfer_clock_pin_out && !xp)
				n++;
			xp = transfer_clock_pin_out;
		end
		chk("clock pin rises", 16'(n), 16'h000a);
		$display("test synchronous master done");
		bit_clks <= 5'h08;
		d = 9'($random(seed));
		send(d, 8'h03, 8'h11);
		fork
			remote.run_xck(12);
			take(exp_frame({1'b0, d[7:0]}, 8'h03), t1);
		join
		wait_st(uft_pkg::ST_TX_DONE, 1'b1);
		$display("test synchronous slave done");
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(uft_pkg::ADDR_STATUS, s);
		chk("status after reset", {8'h0, s}, 16'h0001);
		rd(uft_pkg::ADDR_CTRL, s);
		chk("ctrl after reset", {8'h0, s}, 16'h0000);
		chk("pin free after reset", {15'h0, serial_out_pin_oe}, 16'h0000);
		$display("test reset in run done");
		wrap_up();
	end
endmodule
